// File: rtl/rss_consts.svh
// Constants of the reset source sequencer: offsets, bits, timings.
// Assumes a 10 MHz core clock shared by both ends of the link.
//
// Behaviour
// - Reset pin low starts full hardware reset.
// - Hardware reset hits every domain, reloads, relatches.
// - Soft reset: host bus, MAC interface, MAC, reload.
// - Host resets device at power-up, pin or soft.
// - Host waits for ready before soft reset.
// - Ready reads zero during hardware reset, then sets.
// - Ready about 22 ms; host errors after 100 ms.
// - Reset pin pulled high; unused pin needs soft reset.
// - Hardware and soft resets start an automatic EEPROM presence check.
// - Host waits for EEPROM busy clear first.
// - After PHY reset host waits for link up.
// - Wake write sets ready within 2 ms.
// - Soft reset bit self-clears after about 2 us.
// - PHY reset bit self-clears after about 100 us.
// - PHY control bit 15 resets PHY, self-clears.
// - Any endian-test write wakes; ready clear asleep.
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// Clock period in ns.
`define RSS_CLK_NS 100
// Times in their own units, and derived cycle counts.
`define RSS_HW_RST_MS 30
`define RSS_HW_RST_CYC ((`RSS_HW_RST_MS * 1000000 + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_READY_MS 22
`define RSS_READY_CYC ((`RSS_READY_MS * 1000000) / `RSS_CLK_NS)
`define RSS_WAKE_MS 2
`define RSS_WAKE_CYC ((`RSS_WAKE_MS * 1000000) / `RSS_CLK_NS)
`define RSS_SOFT_RESET_BIT_US 2
`define RSS_SOFT_RESET_BIT_CYC ((`RSS_SOFT_RESET_BIT_US * 1000) / `RSS_CLK_NS)
`define RSS_PHY_US 100
`define RSS_PHY_CYC ((`RSS_PHY_US * 1000) / `RSS_CLK_NS)
`define RSS_TMO_MS 100
`define RSS_TMO_CYC ((`RSS_TMO_MS * 1000000 + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_EE_CYC 16

// Register offsets on the host bus.
`define RSS_A_ENDIAN 8'h64
`define RSS_A_HWCFG 8'h74
`define RSS_A_PMT 8'h84
`define RSS_A_EECMD 8'hB0
`define RSS_A_PHYBCR 8'hC0
`define RSS_A_PHYBSR 8'hC4

// Field positions.
`define RSS_B_SOFT_RESET_BIT 0
`define RSS_B_READY 0
`define RSS_B_PHY_RST 10
`define RSS_B_PM_LO 12
`define RSS_B_PHY_SOFT_RESET_BIT 15
`define RSS_B_LINK 2
`define RSS_B_EE_FOUND 8
`define RSS_B_EE_BUSY 31

// Endian-test pattern; the value is arbitrary.
`define RSS_ENDIAN_VAL 32'h5A5AC3C3
`define RSS_STRAP_W 4

`endif

// File: rtl/rss_device.sv
// Device end: reset sources, domain resets, ready flag, sleep, wake.
// Assumes the host keeps its side of the reset sequence on the link.
`timescale 1ns/1ns
`include "rss_consts.svh"

module rss_device
   import rss_pkg::*;
#(
   parameter logic [23:0] READY_CYC = 24'(`RSS_READY_CYC),
   parameter logic [23:0] WAKE_CYC = 24'(`RSS_WAKE_CYC),
   parameter logic [7:0] SOFT_RESET_BIT_CYC = 8'(`RSS_SOFT_RESET_BIT_CYC),
   parameter logic [15:0] PHY_CYC = 16'(`RSS_PHY_CYC),
   parameter logic [7:0] EE_CYC = 8'(`RSS_EE_CYC)
) (
   // Clock and power-on reset.
   input wire logic clk,
   input wire logic rst,
   // Link to the host.
   rss_link_if.dev link,
   // Pins from the board.
   input wire logic ee_present,
   input wire logic link_up,
   input wire logic [`RSS_STRAP_W-1:0] strap_in,
   // Domain resets.
   output logic rst_pll,
   output logic rst_host_bus,
   output logic rst_immune,
   output logic rst_mac_if,
   output logic rst_mac,
   output logic rst_phy,
   // Status.
   output logic mac_reload,
   output logic strap_latch,
   output logic [`RSS_STRAP_W-1:0] straps,
   output logic ee_busy,
   output logic [1:0] power_state,
   output logic dev_ready
);

   // Counters cannot serve a zero length.
   if (READY_CYC == 0 || WAKE_CYC == 0 || SOFT_RESET_BIT_CYC == 0 ||
       PHY_CYC == 0 || EE_CYC == 0) begin : g_chk
      $error("rss_device: cycle counts must be nonzero");
   end

   rss_dev_t q;
   rss_dev_t d;
   logic hw_act;
   logic in_soft_reset_bit;

   // Read mux; unmapped offsets read as zero.
   function automatic logic [31:0] reg_read(input rss_dev_t s,
                                            input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `RSS_A_ENDIAN: v = `RSS_ENDIAN_VAL;
         `RSS_A_HWCFG: v[`RSS_B_SOFT_RESET_BIT] = s.soft_reset_bit != 8'h00;
         `RSS_A_PMT: begin
            v[`RSS_B_READY] = s.ready;
            v[`RSS_B_PHY_RST] = s.phy != 16'h0000;
            v[`RSS_B_PM_LO +: 2] = s.pm;
         end
         `RSS_A_EECMD: begin
            v[`RSS_B_EE_BUSY] = s.ee != 8'h00;
            v[`RSS_B_EE_FOUND] = s.ee_found;
         end
         `RSS_A_PHYBCR: v[`RSS_B_PHY_SOFT_RESET_BIT] = s.phy15 != 16'h0000;
         `RSS_A_PHYBSR: v[`RSS_B_LINK] = s.ls2 && s.phy == 16'h0000 &&
                                       s.phy15 == 16'h0000;
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Two high samples in a row end reset; a lone high sample is ignored,
   // so a pin pulled low just after power-on gives no false release.
   assign hw_act = !(q.hs2 && q.hw_prev);
   assign in_soft_reset_bit = q.soft_reset_bit != 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      d = q;
      // Pin inputs pass two flops before use.
      d.hs1 = link.hw_reset_in_n;
      d.hs2 = q.hs1;
      d.hw_prev = q.hs2;
      d.hs3 = q.hw_prev;
      d.ls1 = link_up;
      d.ls2 = q.ls1;
      d.es1 = ee_present;
      d.es2 = q.es1;
      d.ss1 = strap_in;
      d.ss2 = q.ss1;
      d.reload = 1'b0;
      d.latch = 1'b0;
      d.rvalid = 1'b0;

      // Self-clearing reset counters.
      if (q.soft_reset_bit != 8'h00) begin
         d.soft_reset_bit = q.soft_reset_bit - 8'h01;
      end
      if (q.phy != 16'h0000) begin
         d.phy = q.phy - 16'h0001;
      end
      if (q.phy15 != 16'h0000) begin
         d.phy15 = q.phy15 - 16'h0001;
      end
      if (q.ee != 8'h00) begin
         d.ee = q.ee - 8'h01;
      end

      // End of soft reset: ready back, address reload and EEPROM check.
      if (q.soft_reset_bit == 8'h01) begin
         d.ready = 1'b1;
         d.ee = EE_CYC;
         d.reload = 1'b1;
         d.ee_found = q.es2;
      end

      // Ready timer after hardware reset or wake.
      if (q.run) begin
         if (q.rtmr == 24'h00_0001) begin
            d.ready = 1'b1;
            d.run = 1'b0;
         end else begin
            d.rtmr = q.rtmr - 24'h00_0001;
         end
      end

      // Reads are answered one cycle later, even while not ready, but not during hardware reset.
      if (link.bus_rd) begin
         d.rvalid = 1'b1;
         d.rdata = reg_read(q, link.bus_addr);
      end

      // Writes; the host bus logic ignores them during soft reset.
      if (link.bus_wr && !in_soft_reset_bit) begin
         case (link.bus_addr)
            `RSS_A_HWCFG: begin
               if (link.bus_wdata[`RSS_B_SOFT_RESET_BIT]) begin
                  d.soft_reset_bit = SOFT_RESET_BIT_CYC;
                  d.ready = 1'b0;
                  d.run = 1'b0;
                  d.ee = 8'h00;
               end
            end
            `RSS_A_PMT: begin
               if (link.bus_wdata[`RSS_B_PHY_RST]) begin
                  d.phy = PHY_CYC;
               end
               if (q.pm == 2'b00 &&
                   link.bus_wdata[`RSS_B_PM_LO +: 2] != 2'b00) begin
                  d.pm = link.bus_wdata[`RSS_B_PM_LO +: 2];
                  d.ready = 1'b0;
                  d.run = 1'b0;
               end
            end
            `RSS_A_PHYBCR: begin
               if (link.bus_wdata[`RSS_B_PHY_SOFT_RESET_BIT]) begin
                  d.phy15 = PHY_CYC;
               end
            end
            `RSS_A_ENDIAN: begin
               // Any data wakes a sleeping device.
               if (q.pm != 2'b00) begin
                  d.pm = 2'b00;
                  d.run = 1'b1;
                  d.rtmr = WAKE_CYC;
               end
            end
            default: d.pm = d.pm;
         endcase
      end

      // Hardware reset overrides everything while the pin is low.
      if (hw_act) begin
         d.ready = 1'b0;
         d.run = 1'b0;
         d.pm = 2'b00;
         d.soft_reset_bit = 8'h00;
         d.phy = 16'h0000;
         d.phy15 = 16'h0000;
         d.ee = 8'h00;
         d.rvalid = 1'b0;
         d.rdata = 32'h0000_0000;
      end else if (!q.hs3) begin
         // First cycle after release: relatch straps, reload, check.
         d.run = 1'b1;
         d.rtmr = READY_CYC;
         d.straps = q.ss2;
         d.latch = 1'b1;
         d.reload = 1'b1;
         d.ee = EE_CYC;
         d.ee_found = q.es2;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; power-on acts as a hardware reset.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Domain resets; all leave reset on the same edge as the pin is seen.
   assign rst_pll = hw_act;
   assign rst_immune = hw_act;
   assign rst_host_bus = hw_act || in_soft_reset_bit;
   assign rst_mac_if = hw_act || in_soft_reset_bit;
   assign rst_mac = hw_act || in_soft_reset_bit;
   // PHY sources touch nothing but the PHY.
   assign rst_phy = hw_act || q.phy != 16'h0000 ||
                    q.phy15 != 16'h0000;
   assign mac_reload = q.reload;
   assign strap_latch = q.latch;
   assign straps = q.straps;
   assign ee_busy = q.ee != 8'h00;
   assign power_state = q.pm;
   assign dev_ready = q.ready;
   assign link.bus_rdata = q.rdata;
   assign link.bus_rvalid = q.rvalid;

endmodule

// File: rtl/rss_host.sv
// Host end: power-up reset, ready polling, PHY reset, sleep and wake.
// Assumes the device answers each read one cycle after the strobe.
`timescale 1ns/1ns
`include "rss_consts.svh"

module rss_host
   import rss_pkg::*;
#(
   parameter logic [23:0] HW_RST_CYC = 24'(`RSS_HW_RST_CYC),
   parameter logic [23:0] TMO_CYC = 24'(`RSS_TMO_CYC)
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Link to the device.
   rss_link_if.host link,
   // User commands and status.
   input wire logic use_hw_reset,
   input wire logic cmd_phy_rst,
   input wire logic cmd_sleep,
   input wire logic cmd_wake,
   output logic idle,
   output logic traffic_ok,
   output logic fault
);

   if (HW_RST_CYC == 0 || TMO_CYC == 0) begin : g_chk
      $error("rss_host: cycle counts must be nonzero");
   end

   rss_host_t q;
   rss_host_t d;
   logic got;

   assign got = q.pend && link.bus_rvalid;

   ////////////////////////////////////////////////////////////////////////
   // Next state. Poll states issue one read and act on its answer.
   always_comb begin
      d = q;
      d.wr = 1'b0;
      d.rd = 1'b0;
      // A read refused during hardware reset gets no answer; drop, retry.
      if (got || (q.pend && !q.rd)) begin
         d.pend = 1'b0;
      end
      unique case (q.st)
         H_PIN: begin
            // Hold the pin low for the least time, or leave it to the pull.
            d.rst_oe = use_hw_reset;
            d.cnt = q.cnt + 24'h00_0001;
            if (!use_hw_reset || q.cnt == HW_RST_CYC) begin
               d.rst_oe = 1'b0;
               d.soft_reset_bit_done = use_hw_reset;
               d.cnt = 24'h00_0000;
               d.st = H_RDY;
            end
         end
         H_RDY, H_WAKE: begin
            d.cnt = q.cnt + 24'h00_0001;
            if (!q.pend) begin
               d.rd = 1'b1;
               d.pend = 1'b1;
               d.addr = `RSS_A_PMT;
            end else if (got && link.bus_rdata[`RSS_B_READY]) begin
               // Soft reset only once ready is seen.
               d.st = q.soft_reset_bit_done ? H_EE : H_SOFT_RESET_BIT;
            end
            if (q.cnt == TMO_CYC) begin
               d.st = H_FAULT;
            end
         end
         H_SOFT_RESET_BIT: begin
            d.wr = 1'b1;
            d.addr = `RSS_A_HWCFG;
            d.wdata = 32'h0000_0001;
            d.soft_reset_bit_done = 1'b1;
            d.st = H_WSRST;
         end
         H_WSRST: begin
            if (!q.pend) begin
               d.rd = 1'b1;
               d.pend = 1'b1;
               d.addr = `RSS_A_HWCFG;
            end else if (got && !link.bus_rdata[`RSS_B_SOFT_RESET_BIT]) begin
               d.st = H_EE;
            end
         end
         H_EE: begin
            if (!q.pend) begin
               d.rd = 1'b1;
               d.pend = 1'b1;
               d.addr = `RSS_A_EECMD;
            end else if (got && !link.bus_rdata[`RSS_B_EE_BUSY]) begin
               d.st = H_IDLE;
               d.traffic_ok = 1'b1;
            end
         end
         H_IDLE: begin
            if (cmd_phy_rst) begin
               d.wr = 1'b1;
               d.addr = `RSS_A_PMT;
               d.wdata = 32'h0000_0400;
               d.traffic_ok = 1'b0;
               d.st = H_WPHY;
            end else if (cmd_sleep) begin
               d.wr = 1'b1;
               d.addr = `RSS_A_PMT;
               d.wdata = 32'h0000_1000;
               d.traffic_ok = 1'b0;
               d.st = H_SLEEP;
            end
         end
         H_WPHY: begin
            if (!q.pend) begin
               d.rd = 1'b1;
               d.pend = 1'b1;
               d.addr = `RSS_A_PMT;
            end else if (got && !link.bus_rdata[`RSS_B_PHY_RST]) begin
               d.st = H_LINK;
            end
         end
         H_LINK: begin
            if (!q.pend) begin
               d.rd = 1'b1;
               d.pend = 1'b1;
               d.addr = `RSS_A_PHYBSR;
            end else if (got && link.bus_rdata[`RSS_B_LINK]) begin
               d.traffic_ok = 1'b1;
               d.st = H_IDLE;
            end
         end
         H_SLEEP: begin
            if (cmd_wake) begin
               d.wr = 1'b1;
               d.addr = `RSS_A_ENDIAN;
               d.wdata = 32'h0000_0000;
               d.cnt = 24'h00_0000;
               d.st = H_WAKE;
            end
         end
         H_FAULT: begin
            d.fault = 1'b1;
         end
         default: d.st = H_FAULT;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '{st: H_PIN, default: '0};
      end else begin
         q <= d;
      end
   end

   assign link.rst_out_n = 1'b0;
   assign link.rst_oe = q.rst_oe;
   assign link.bus_wr = q.wr;
   assign link.bus_rd = q.rd;
   assign link.bus_addr = q.addr;
   assign link.bus_wdata = q.wdata;
   assign idle = q.st == H_IDLE;
   assign traffic_ok = q.traffic_ok;
   assign fault = q.fault;

endmodule

// File: rtl/rss_link_if.sv
// Link between the host and the device: reset pin and host bus.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns

interface rss_link_if;
   // Reset pin as driven by the host, and as the device sees it.
   logic rst_out_n;
   logic rst_oe;
   logic hw_reset_in_n;
   // Host bus.
   logic bus_wr;
   logic bus_rd;
   logic [7:0] bus_addr;
   logic [31:0] bus_wdata;
   logic [31:0] bus_rdata;
   logic bus_rvalid;

   // The weak pull-up holds the pin high when nobody drives it.
   assign hw_reset_in_n = rst_oe ? rst_out_n : 1'b1;

   modport dev (
      input hw_reset_in_n,
      input bus_wr,
      input bus_rd,
      input bus_addr,
      input bus_wdata,
      output bus_rdata,
      output bus_rvalid
   );
   modport host (
      output rst_out_n,
      output rst_oe,
      output bus_wr,
      output bus_rd,
      output bus_addr,
      output bus_wdata,
      input bus_rdata,
      input bus_rvalid
   );
endinterface

// File: rtl/rss_pkg.sv
// Types shared by the two ends of the reset source sequencer.
// Assumes rss_consts.svh is on the include path.
`include "rss_consts.svh"

package rss_pkg;

   // Device state, registered as one word.
   typedef struct packed {
      logic hs1;
      logic hs2;
      logic hw_prev;
      logic hs3;
      logic ls1;
      logic ls2;
      logic es1;
      logic es2;
      logic [`RSS_STRAP_W-1:0] ss1;
      logic [`RSS_STRAP_W-1:0] ss2;
      logic [`RSS_STRAP_W-1:0] straps;
      logic ready;
      logic [1:0] pm;
      logic run;
      logic [23:0] rtmr;
      logic [7:0] soft_reset_bit;
      logic [15:0] phy;
      logic [15:0] phy15;
      logic [7:0] ee;
      logic ee_found;
      logic reload;
      logic latch;
      logic [31:0] rdata;
      logic rvalid;
   } rss_dev_t;

   // Host sequencer states, one-hot.
   typedef enum logic [10:0] {
      H_PIN = 11'h001,
      H_RDY = 11'h002,
      H_SOFT_RESET_BIT = 11'h004,
      H_WSRST = 11'h008,
      H_EE = 11'h010,
      H_IDLE = 11'h020,
      H_WPHY = 11'h040,
      H_LINK = 11'h080,
      H_SLEEP = 11'h100,
      H_WAKE = 11'h200,
      H_FAULT = 11'h400
   } rss_hst_t;

   // Host state, registered as one word.
   typedef struct packed {
      rss_hst_t st;
      logic [23:0] cnt;
      logic pend;
      logic soft_reset_bit_done;
      logic rst_oe;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic traffic_ok;
      logic fault;
   } rss_host_t;

endpackage

// File: tb/reset_source_sequencer_tb_top.sv
// Bench of the reset source sequencer: host and device on one link.
// Assumes the design files and rss_consts.svh are compiled first.
`timescale 1ns/1ns
`include "rss_consts.svh"

module reset_source_sequencer_tb_top
   import rss_pkg::*;
;
   // Shortened counts keep the run brief; expectations use them too.
   localparam int RDY = 50;
   localparam int WK = 30;
   localparam int SR = 20;
   localparam int PH = 40;
   localparam int HW = 20;

   logic clk, rst, use_hw_reset, ee_present, link_up;
   logic [2:0] cmd;
   logic [`RSS_STRAP_W-1:0] strap_in, d_straps;
   logic [1:0] d_pm;
   logic d_pll, d_hbus, d_immune, d_macif, d_mac, d_phy, d_reload, d_latch;
   logic d_eebusy, d_ready, idle, traffic_ok, fault;
   logic all_rst, soft_ok, phy_ok;
   int n_mismatch, comparisons, soft_cyc, phy_cyc, latch_n, reload_n;
   int ee_n, pinlow_n, pl_run, rel, first_rdy, n;

   assign all_rst = &{d_pll, d_hbus, d_immune, d_macif, d_mac, d_phy};
   assign soft_ok = d_hbus && d_macif && !d_immune && !d_phy && !d_ready;
   assign phy_ok = !(d_hbus || d_macif || d_immune || d_pll);

   ////////////////////////////////////////////////////////////////////////
   rss_link_if u_rss_link_if ();

   rss_host #(.HW_RST_CYC(24'(HW)), .TMO_CYC(24'(500))) u_rss_host (
      .clk(clk), .rst(rst), .link(u_rss_link_if.host),
      .use_hw_reset(use_hw_reset), .cmd_phy_rst(cmd[0]),
      .cmd_sleep(cmd[1]), .cmd_wake(cmd[2]), .idle(idle),
      .traffic_ok(traffic_ok), .fault(fault));

   rss_device #(.READY_CYC(24'(RDY)), .WAKE_CYC(24'(WK)), .SOFT_RESET_BIT_CYC(8'(SR)),
      .PHY_CYC(16'(PH)), .EE_CYC(8'(16))) u_rss_device (
      .clk(clk), .rst(rst), .link(u_rss_link_if.dev),
      .ee_present(ee_present), .link_up(link_up), .strap_in(strap_in),
      .rst_pll(d_pll), .rst_host_bus(d_hbus), .rst_immune(d_immune),
      .rst_mac_if(d_macif),
      .rst_mac(d_mac), .rst_phy(d_phy), .mac_reload(d_reload),
      .strap_latch(d_latch), .straps(d_straps), .ee_busy(d_eebusy),
      .power_state(d_pm), .dev_ready(d_ready));

   rss_link_chk #(.READY_CYC(RDY), .WAKE_CYC(WK), .SOFT_RESET_BIT_CYC(SR),
      .PHY_CYC(PH), .HW_RST_CYC(HW)) u_rss_link_chk (
      .clk(clk), .rst(rst), .rst_out_n(u_rss_link_if.rst_out_n),
      .rst_oe(u_rss_link_if.rst_oe),
      .hw_reset_in_n(u_rss_link_if.hw_reset_in_n),
      .bus_wr(u_rss_link_if.bus_wr), .bus_rd(u_rss_link_if.bus_rd),
      .bus_addr(u_rss_link_if.bus_addr),
      .bus_wdata(u_rss_link_if.bus_wdata),
      .bus_rdata(u_rss_link_if.bus_rdata),
      .bus_rvalid(u_rss_link_if.bus_rvalid));

   // Clock of 100 ns.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic clr();
      {soft_cyc, phy_cyc, latch_n, reload_n, ee_n, pinlow_n, first_rdy} = '0;
   endtask

   // Commands are one-cycle pulses, as the host takes them.
   task automatic pulse(input logic [2:0] c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= 3'h0;
   endtask

   task automatic do_reset(input logic hw);
      @(posedge clk);
      rst <= 1'b1;
      use_hw_reset <= hw;
      clr();
      repeat (6) @(posedge clk);
      rst <= 1'b0;
   endtask

   task automatic wait_idle(input int lim);
      int i;
      i = 0;
      @(negedge clk);
      while (idle !== 1'b1 && i < lim) begin
         @(negedge clk);
         i++;
      end
      chk(idle === 1'b1, "host never reached idle");
   endtask

   task automatic end_sim();
      $display("counts: %0d comparisons, %0d mismatches", comparisons,
         n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Sample well after each edge so registered outputs have settled.
   always begin
      @(posedge clk);
      #10;
      pl_run = u_rss_link_if.hw_reset_in_n ? 0 : pl_run + 1;
      pinlow_n += int'(pl_run != 0);
      rel = (rst || pl_run != 0) ? 0 : rel + 1;
      if (d_ready === 1'b1 && first_rdy == 0)
         first_rdy = rel;
      if (pl_run > 2)
         chk(all_rst && !d_ready, "pin reset state");
      if (d_mac && !d_pll) begin
         soft_cyc++;
         chk(soft_ok, "soft reset domains");
      end
      if (d_phy && !d_mac) begin
         phy_cyc++;
         chk(phy_ok, "phy reset reached other domains");
      end
      latch_n += int'(d_latch);
      reload_n += int'(d_reload);
      ee_n += int'(d_eebusy);
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      use_hw_reset = 1'b1;
      ee_present = 1'b1;
      link_up = 1'b1;
      cmd = 3'h0;
      strap_in = 4'hA;
      {n_mismatch, comparisons, pl_run, rel, n} = '0;
      clr();
      do_reset(1'b1);
      wait_idle(400);
      chk(traffic_ok === 1'b1 && fault === 1'b0, "pin path");
      chk(d_eebusy === 1'b0, "eeprom check over at idle");
      chk(first_rdy >= RDY && first_rdy <= RDY + 6, "ready delay");
      chk(latch_n == 1 && reload_n == 1, "pin side effects");
      chk(ee_n == 16 && d_straps === 4'hA, "straps, check");
      $display("test pin_reset done");
      // A second power-on reset in mid-run, with the pin left unused.
      @(posedge clk);
      strap_in <= 4'h5;
      do_reset(1'b0);
      wait_idle(400);
      chk(traffic_ok === 1'b1 && d_ready === 1'b1, "soft path");
      chk(pinlow_n == 0, "pin stayed high");
      chk(soft_cyc == SR, "soft reset length");
      chk(latch_n == 1 && reload_n == 2, "soft side effects");
      chk(ee_n == 32 && d_straps === 4'h5, "straps, check");
      $display("test soft_reset done");
      @(posedge clk);
      link_up <= 1'b0;
      strap_in <= 4'h3;
      clr();
      pulse(3'h1);
      repeat (PH + 30) @(negedge clk);
      chk(traffic_ok === 1'b0 && idle === 1'b0, "link wait");
      @(posedge clk);
      link_up <= 1'b1;
      wait_idle(60);
      chk(traffic_ok === 1'b1, "traffic after link");
      chk(phy_cyc == PH, "phy reset length");
      chk(latch_n == 0 && d_straps === 4'h5, "phy reset only");
      $display("test phy_reset done");
      pulse(3'h2);
      repeat (5) @(negedge clk);
      chk(d_pm === 2'b01 && d_ready === 1'b0, "asleep");
      pulse(3'h4);
      while (d_ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk(n >= WK - 2 && n <= WK + 5, "wake delay");
      wait_idle(60);
      chk(d_pm === 2'b00 && traffic_ok === 1'b1, "awake");
      $display("test sleep_wake done");
      end_sim();
   end

   // Watchdog: the tests need well under 1000 cycles.
   initial begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule

// File: tb/rss_link_chk.sv
// Checker of the link between host and device: reset pin and host bus.
// Assumes it sees the interface signals of the one joined pair.
`timescale 1ns/1ns
`include "rss_consts.svh"

module rss_link_chk
   import rss_pkg::*;
#(
   parameter int READY_CYC = 50,
   parameter int WAKE_CYC = 30,
   parameter int SOFT_RESET_BIT_CYC = 20,
   parameter int PHY_CYC = 40,
   parameter int HW_RST_CYC = 20
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Reset pin.
   input wire logic rst_out_n,
   input wire logic rst_oe,
   input wire logic hw_reset_in_n,
   // Host bus.
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic [31:0] bus_rdata,
   input wire logic bus_rvalid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Mirrors of the device counters, rebuilt from bus traffic and the reset pin.
   logic [9:0] rel_q, oe_q, wk_q;
   logic [7:0] ra_q, sr_q;
   logic [15:0] ph_q;
   logic rdy_q, slp_q, wake_q, rsr_q, rph_q;
   logic wr_pmt, wr_end, rd_pmt;
   assign wr_pmt = bus_wr && bus_addr == `RSS_A_PMT;
   assign wr_end = bus_wr && bus_addr == `RSS_A_ENDIAN;
   assign rd_pmt = bus_rvalid && ra_q == `RSS_A_PMT;

   // Pin low clears the mirrors, since the device forgets all state then.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {rel_q, oe_q, wk_q, ra_q, sr_q, ph_q} <= '0;
         {rdy_q, slp_q, wake_q, rsr_q, rph_q} <= '0;
      end else begin
         oe_q <= rst_oe ? oe_q + 10'h001 : 10'h000;
         if (!hw_reset_in_n) begin
            {rel_q, wk_q, ra_q, sr_q, ph_q} <= '0;
            {rdy_q, slp_q, wake_q, rsr_q, rph_q} <= '0;
         end else begin
            rel_q <= rel_q + 10'(rel_q != 10'h3FF);
            wk_q <= wk_q + 10'(wk_q != 10'h3FF);
            if (bus_wr && bus_addr == `RSS_A_HWCFG && bus_wdata[0] && sr_q == 0)
               sr_q <= 8'(SOFT_RESET_BIT_CYC);
            else if (sr_q != 8'h00)
               sr_q <= sr_q - 8'h01;
            if (wr_pmt && bus_wdata[10] && ph_q == 16'h0000)
               ph_q <= 16'(PHY_CYC);
            else if (ph_q != 16'h0000)
               ph_q <= ph_q - 16'h0001;
            if (bus_rd) begin
               ra_q <= bus_addr;
               rsr_q <= sr_q != 8'h00;
               rph_q <= ph_q != 16'h0000;
            end
            if (rd_pmt && bus_rdata[0]) begin
               rdy_q <= 1'b1;
               wake_q <= 1'b0;
            end
            if (wr_pmt && bus_wdata[13:12] != 2'b00)
               slp_q <= 1'b1;
            if (wr_end && slp_q) begin
               slp_q <= 1'b0;
               wake_q <= 1'b1;
               wk_q <= 10'h000;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_PIN_DRIVE: assert property (rst_oe |-> !rst_out_n)
      else $error("host drives the reset pin high");
   AST_PIN_HOLD: assert property ($fell(rst_oe)
      |-> oe_q >= HW_RST_CYC)
      else $error("reset pin released too early");
   AST_SOFT_LATE: assert property (bus_wr && bus_wdata[0]
      && bus_addr == `RSS_A_HWCFG |-> rdy_q)
      else $error("soft reset before ready was seen");
   AST_RDY_EARLY: assert property (rd_pmt && rel_q < READY_CYC
      |-> !bus_rdata[0])
      else $error("ready read as set during reset");
   AST_RDY_LATE: assert property (bus_rd && !rdy_q
      && bus_addr == `RSS_A_PMT && !wake_q |-> rel_q <= READY_CYC + 8)
      else $error("ready still clear after its delay");
   AST_WAKE_LATE: assert property (bus_rd && wake_q
      && bus_addr == `RSS_A_PMT |-> wk_q <= WAKE_CYC + 8)
      else $error("ready late after wake write");
   AST_WAKE_EARLY: assert property (rd_pmt && wake_q
      && wk_q < WAKE_CYC - 2 |-> !bus_rdata[0])
      else $error("ready set while still waking");
   AST_SOFT_RESET_BIT_BIT: assert property (bus_rvalid
      && ra_q == `RSS_A_HWCFG |-> bus_rdata[0] == rsr_q)
      else $error("soft reset bit wrong");
   AST_PHY_BIT: assert property (rd_pmt
      |-> bus_rdata[10] == rph_q)
      else $error("phy reset bit wrong");
   AST_READ_ANS: assert property (bus_rd && rel_q > 3
      |=> bus_rvalid)
      else $error("read not answered");

   // Main scenarios.
   COV_PIN: cover property ($fell(rst_oe));
   COV_SOFT: cover property (bus_wr && bus_addr == `RSS_A_HWCFG);
   COV_WAKE: cover property (wr_end && slp_q);
endmodule
